//--- dmc_channel_ctrl.v
// four channel dma register set, shared status and completion interrupts
// Functional notes
// - four independent channels, each full register set
// - control register is sixteen bits
// - sixteen-bit request select picks trigger irq
// - primary and secondary 32-bit ram starts
// - sixteen-bit peripheral address per channel
// - fourteen-bit transfer count sets block length
// - shared status reports write, request collisions
// - shared status keeps last address, channel
// - completion flags live in interrupt flag register
`timescale 1ns/1ps
`include "dmc_defines.vh"
module dmc_channel_ctrl #(
  parameter NCH = 4,
  parameter CNT_W = 14
)
(
  input wire sys_clk,
  input wire reset_n,
  input wire [5:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_ff,
  input wire [127:0] periph_irq,
  input wire [3:0] periph_wr_coll,
  output reg [3:0] chan_done_flag_ff,
  output reg [3:0] xfer_grant_ff,
  output reg [31:0] last_ram_addr_ff,
  output reg [15:0] periph_addr_out_ff,
  output reg xfer_dir_ff,
  output reg irq_ff
);
  //////////////////////////////////////////////////////////////////////////
  // per channel storage, flip-flops indexed by channel
  reg [15:0] chan_ctrl_reg [0:3];
  reg [15:0] chan_req_select_reg [0:3];
  reg [31:0] ram_start_primary [0:3];
  reg [31:0] ram_start_secondary [0:3];
  reg [15:0] periph_addr_reg [0:3];
  reg [CNT_W-1:0] xfer_count_reg [0:3];
  // shared status
  reg [3:0] periph_write_collision_status;
  reg [3:0] request_collision_status;
  reg [3:0] last_channel_status;
  reg [3:0] irq_mask_ff; // mask for completion flags
  // request sync, two stages, first read only by second
  reg [127:0] irq_s1_ff;
  reg [127:0] irq_s2_ff;
  reg [3:0] pend_ff; // pending triggers per channel
  reg [3:0] wcol_s1_ff;
  reg [3:0] wcol_s2_ff;
  // engine side
  wire [31:0] eng_addr [0:3];
  wire [3:0] eng_buf;
  wire [3:0] eng_done;
  wire [3:0] eng_dis;
  reg [3:0] trig;
  reg [1:0] win;
  reg any_req;
  integer i; // arbiter loop index
  integer ci; // combinational trigger loop index
  integer ri; // register process loop index
  integer fi; // flag process loop index
  wire ch_win;
  wire [1:0] ch;
  wire [2:0] slot;
  assign ch_win = ~reg_addr[5];
  assign ch = reg_addr[4:3];
  assign slot = reg_addr[2:0];
  //////////////////////////////////////////////////////////////////////////
  // lowest channel number wins when several are pending
  function [1:0] pick;
    input [3:0] req;
    begin
      if (req[0])
        pick = 2'd0;
      else if (req[1])
        pick = 2'd1;
      else if (req[2])
        pick = 2'd2;
      else
        pick = 2'd3;
    end
  endfunction
  // selected peripheral irq line of a channel
  function sel_irq;
    input [127:0] lines;
    input [15:0] sel;
    begin
      sel_irq = lines[sel[6:0]];
    end
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // request synchronisers; sources are pins or other domains
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_s1_ff <= 128'h0;
      irq_s2_ff <= 128'h0;
      wcol_s1_ff <= 4'h0;
      wcol_s2_ff <= 4'h0;
    end
    else
    begin
      irq_s1_ff <= periph_irq;
      irq_s2_ff <= irq_s1_ff;
      wcol_s1_ff <= periph_wr_coll;
      wcol_s2_ff <= wcol_s1_ff;
    end
  end
  // per channel trigger from its chosen request line
  always @*
  begin
    for (ci = 0; ci < NCH; ci = ci + 1)
      trig[ci] = chan_ctrl_reg[ci][`DMC_CTRL_EN] &
        sel_irq(irq_s2_ff, chan_req_select_reg[ci]);
    any_req = |pend_ff;
    win = pick(pend_ff);
  end
  //////////////////////////////////////////////////////////////////////////
  // one engine per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : eng
      dmc_xfer_engine #(
        .CNT_W(CNT_W)
      ) u_eng (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .enable(chan_ctrl_reg[g][`DMC_CTRL_EN]),
        .ctrl(chan_ctrl_reg[g]),
        .count(xfer_count_reg[g]),
        .start_a(ram_start_primary[g]),
        .start_b(ram_start_secondary[g]),
        .grant(xfer_grant_ff[g]),
        .ram_addr_ff(eng_addr[g]),
        .buf_sel_ff(eng_buf[g]),
        .done_ff(eng_done[g]),
        .disable_ff(eng_dis[g])
      );
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////////
  // arbiter, pending requests, collisions and shared status
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_ff <= 4'h0;
      xfer_grant_ff <= 4'h0;
      request_collision_status <= 4'h0;
      periph_write_collision_status <= 4'h0;
      last_channel_status <= `DMC_RST_LCA;
      last_ram_addr_ff <= `DMC_RST_32;
      periph_addr_out_ff <= `DMC_RST_16;
      xfer_dir_ff <= 1'b0;
    end
    else
    begin
      xfer_grant_ff <= 4'h0;
      for (i = 0; i < NCH; i = i + 1)
      begin
        // a second trigger while one is pending is a collision
        if (trig[i] && pend_ff[i])
          request_collision_status[i] <= 1'b1;
        else if (reg_wr && !ch_win && slot == `DMC_SH_RQC && reg_wdata[i])
          request_collision_status[i] <= 1'b0;
        if (wcol_s2_ff[i] && chan_ctrl_reg[i][`DMC_CTRL_EN])
          periph_write_collision_status[i] <= 1'b1;
        else if (reg_wr && !ch_win && slot == `DMC_SH_PWC && reg_wdata[i])
          periph_write_collision_status[i] <= 1'b0;
      end
      pend_ff <= (pend_ff | trig) & ~(any_req ? (4'h1 << win) : 4'h0);
      if (any_req)
      begin
        // serve one element, record address and channel
        xfer_grant_ff <= 4'h1 << win;
        last_channel_status <= {2'b00, win};
        last_ram_addr_ff <= eng_addr[win];
        periph_addr_out_ff <= periph_addr_reg[win];
        xfer_dir_ff <= chan_ctrl_reg[win][`DMC_CTRL_DIR];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // register writes; engine one-shot end clears the enable
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (ri = 0; ri < NCH; ri = ri + 1)
      begin
        chan_ctrl_reg[ri] <= `DMC_RST_16;
        chan_req_select_reg[ri] <= `DMC_RST_16;
        ram_start_primary[ri] <= `DMC_RST_32;
        ram_start_secondary[ri] <= `DMC_RST_32;
        periph_addr_reg[ri] <= `DMC_RST_16;
        xfer_count_reg[ri] <= `DMC_RST_14;
      end
      irq_mask_ff <= 4'h0;
    end
    else
    begin
      for (ri = 0; ri < NCH; ri = ri + 1)
        if (eng_dis[ri])
          chan_ctrl_reg[ri][`DMC_CTRL_EN] <= 1'b0;
      if (reg_wr && ch_win)
      begin
        case (slot)
          `DMC_REG_CTRL: chan_ctrl_reg[ch] <= reg_wdata[15:0] & `DMC_CTRL_MASK;
          `DMC_REG_REQ: chan_req_select_reg[ch] <= reg_wdata[15:0];
          `DMC_REG_STA: ram_start_primary[ch] <= reg_wdata;
          `DMC_REG_STB: ram_start_secondary[ch] <= reg_wdata;
          `DMC_REG_PAD: periph_addr_reg[ch] <= reg_wdata[15:0];
          `DMC_REG_CNT: xfer_count_reg[ch] <= reg_wdata[CNT_W-1:0];
          default: ;
        endcase
      end
      else if (reg_wr && slot == `DMC_SH_IMASK)
        irq_mask_ff <= reg_wdata[3:0];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // sticky completion flags, set wins over write-one-to-clear
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chan_done_flag_ff <= 4'h0;
      irq_ff <= 1'b0;
    end
    else
    begin
      for (fi = 0; fi < NCH; fi = fi + 1)
        if (eng_done[fi])
          chan_done_flag_ff[fi] <= 1'b1;
        else if (reg_wr && !ch_win && slot == `DMC_SH_IFLAG && reg_wdata[fi])
          chan_done_flag_ff[fi] <= 1'b0;
      irq_ff <= |((chan_done_flag_ff | eng_done) & irq_mask_ff);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // read data, valid in the cycle after the strobe; unmapped reads zero
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata_ff <= `DMC_RST_32;
    else if (reg_rd && ch_win)
    begin
      case (slot)
        `DMC_REG_CTRL: reg_rdata_ff <= {16'h0000, chan_ctrl_reg[ch]};
        `DMC_REG_REQ: reg_rdata_ff <= {16'h0000, chan_req_select_reg[ch]};
        `DMC_REG_STA: reg_rdata_ff <= ram_start_primary[ch];
        `DMC_REG_STB: reg_rdata_ff <= ram_start_secondary[ch];
        `DMC_REG_PAD: reg_rdata_ff <= {16'h0000, periph_addr_reg[ch]};
        `DMC_REG_CNT: reg_rdata_ff <= {18'h00000, xfer_count_reg[ch]};
        default: reg_rdata_ff <= `DMC_RST_32;
      endcase
    end
    else if (reg_rd)
    begin
      case (slot)
        `DMC_SH_PWC: reg_rdata_ff <= {28'h0000000, periph_write_collision_status};
        `DMC_SH_RQC: reg_rdata_ff <= {28'h0000000, request_collision_status};
        `DMC_SH_PPS: reg_rdata_ff <= {28'h0000000, eng_buf};
        `DMC_SH_LCA: reg_rdata_ff <= {28'h0000000, last_channel_status};
        `DMC_SH_SADR: reg_rdata_ff <= last_ram_addr_ff;
        `DMC_SH_IFLAG: reg_rdata_ff <= {28'h0000000, chan_done_flag_ff};
        `DMC_SH_IMASK: reg_rdata_ff <= {28'h0000000, irq_mask_ff};
        default: reg_rdata_ff <= `DMC_RST_32;
      endcase
    end
    else
      reg_rdata_ff <= `DMC_RST_32;
  end
endmodule // dmc_channel_ctrl

//--- dmc_defines.vh
// register map, field positions and reset values for the dma channel control block
`ifndef DMC_DEFINES_VH
`define DMC_DEFINES_VH
// channel register slots, word index within a channel window
`define DMC_REG_CTRL 3'h0
`define DMC_REG_REQ 3'h1
`define DMC_REG_STA 3'h2
`define DMC_REG_STB 3'h3
`define DMC_REG_PAD 3'h4
`define DMC_REG_CNT 3'h5
// shared status window, selected by address bit 5
`define DMC_SH_PWC 3'h0
`define DMC_SH_RQC 3'h1
`define DMC_SH_PPS 3'h2
`define DMC_SH_LCA 3'h3
`define DMC_SH_SADR 3'h4
`define DMC_SH_IFLAG 3'h5
`define DMC_SH_IMASK 3'h6
// control register fields
`define DMC_CTRL_EN 15
`define DMC_CTRL_SIZE 14
`define DMC_CTRL_DIR 13
`define DMC_CTRL_HALF 12
`define DMC_CTRL_NULLW 11
`define DMC_CTRL_MASK 16'hF833
`define DMC_MODE_LO 0
`define DMC_MODE_ONESHOT 0
`define DMC_MODE_PINGPONG 1
// reset values
`define DMC_RST_16 16'h0000
`define DMC_RST_32 32'h00000000
`define DMC_RST_14 14'h0000
`define DMC_RST_LCA 4'hF
`endif

//--- dmc_xfer_engine.v
// one channel transfer sequencer: counts elements, ping-pong, completion
`timescale 1ns/1ps
`include "dmc_defines.vh"
module dmc_xfer_engine #(
  parameter CNT_W = 14
)
(
  input wire sys_clk,
  input wire reset_n,
  input wire enable,
  input wire [15:0] ctrl,
  input wire [CNT_W-1:0] count,
  input wire [31:0] start_a,
  input wire [31:0] start_b,
  input wire grant,
  output reg [31:0] ram_addr_ff,
  output reg buf_sel_ff,
  output reg done_ff,
  output reg disable_ff
);
  reg [CNT_W-1:0] idx_ff; // elements moved in this block
  reg half_sent_ff; // half event already raised this block
  wire [CNT_W-1:0] nxt_idx; // next element index
  wire [CNT_W-1:0] half_pt;
  wire [31:0] step;
  wire block_end;
  assign half_pt = count >> 1;
  assign nxt_idx = idx_ff + 1'b1;
  // byte steps one, word steps two
  assign step = ctrl[`DMC_CTRL_SIZE] ? 32'h00000001 : 32'h00000002;
  assign block_end = (idx_ff == count);
  //////////////////////////////////////////////////////////////////////////
  // element counter and ram address; count holds transfers minus one
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idx_ff <= `DMC_RST_14;
      ram_addr_ff <= `DMC_RST_32;
      buf_sel_ff <= 1'b0;
      done_ff <= 1'b0;
      half_sent_ff <= 1'b0;
      disable_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      disable_ff <= 1'b0;
      if (!enable)
      begin
        // idle channel rearms at the primary buffer
        idx_ff <= `DMC_RST_14;
        buf_sel_ff <= 1'b0;
        half_sent_ff <= 1'b0;
        ram_addr_ff <= start_a;
      end
      else if (grant)
      begin
        if (block_end)
        begin
          // half mode flags only at midpoint
          done_ff <= ~ctrl[`DMC_CTRL_HALF];
          idx_ff <= `DMC_RST_14;
          half_sent_ff <= 1'b0;
          if (ctrl[`DMC_MODE_PINGPONG])
          begin
            buf_sel_ff <= ~buf_sel_ff;
            ram_addr_ff <= buf_sel_ff ? start_a : start_b;
            disable_ff <= ctrl[`DMC_MODE_ONESHOT] & buf_sel_ff;
          end
          else
          begin
            ram_addr_ff <= start_a;
            disable_ff <= ctrl[`DMC_MODE_ONESHOT];
          end
        end
        else
        begin
          idx_ff <= nxt_idx;
          ram_addr_ff <= ram_addr_ff + step;
          if (ctrl[`DMC_CTRL_HALF] && !half_sent_ff && idx_ff == half_pt)
          begin
            done_ff <= 1'b1;
            half_sent_ff <= 1'b1;
          end
        end
      end
    end
  end
endmodule // dmc_xfer_engine

//--- dmc_ctrl_sva.sv
// port level assertion checker for the dma channel control block
`timescale 1ns/1ps
module dmc_ctrl_sva (
  input wire sys_clk,
  input wire reset_n,
  input wire reg_rd,
  input wire reg_wr,
  input wire [31:0] reg_rdata_ff,
  input wire [3:0] chan_done_flag_ff,
  input wire [3:0] xfer_grant_ff,
  input wire [31:0] last_ram_addr_ff,
  input wire [15:0] periph_addr_out_ff,
  input wire xfer_dir_ff,
  input wire irq_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // read data only in the cycle after a read strobe
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0)
    else $error("read data not zero outside read answer");
  a_grant_one_hot: assert property ($onehot0(xfer_grant_ff))
    else $error("more than one channel granted");
  a_irq_no_flag: assert property (chan_done_flag_ff == 4'h0
    |=> !irq_ff || chan_done_flag_ff != 4'h0)
    else $error("interrupt without completion flag");
  a_irq_has_cause: assert property (irq_ff
    |-> $past(chan_done_flag_ff) != 4'h0 || chan_done_flag_ff != 4'h0)
    else $error("interrupt high with no flag one cycle before");
  // a sticky flag only drops after a software write
  a_flag_stays_set: assert property (($past(chan_done_flag_ff) & ~chan_done_flag_ff) != 4'h0
    |-> $past(reg_wr))
    else $error("completion flag dropped without a write");
  a_flag_after_grant: assert property ((chan_done_flag_ff & ~$past(chan_done_flag_ff)) != 4'h0
    |-> (|xfer_grant_ff) || (|$past(xfer_grant_ff)) || (|$past(xfer_grant_ff, 2)))
    else $error("completion flag set without a served element");
  a_addr_on_grant: assert property ($changed(last_ram_addr_ff)
    |-> (|xfer_grant_ff) || (|$past(xfer_grant_ff)))
    else $error("last address moved without a grant");
  a_periph_on_grant: assert property ($changed({xfer_dir_ff, periph_addr_out_ff})
    |-> (|xfer_grant_ff) || (|$past(xfer_grant_ff)))
    else $error("peripheral address moved without a grant");
  // no disable here: the reset itself is the cause
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n
    |-> xfer_grant_ff == 4'h0 && !irq_ff && reg_rdata_ff == 32'h0)
    else $error("outputs active during reset");
  c_grant: cover property (|xfer_grant_ff);
  c_irq: cover property ($rose(irq_ff));
  c_flag: cover property (chan_done_flag_ff != 4'h0);
endmodule // dmc_ctrl_sva
bind dmc_channel_ctrl dmc_ctrl_sva u_sva (.sys_clk(sys_clk), .reset_n(reset_n),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata_ff(reg_rdata_ff),
  .chan_done_flag_ff(chan_done_flag_ff), .xfer_grant_ff(xfer_grant_ff),
  .last_ram_addr_ff(last_ram_addr_ff), .periph_addr_out_ff(periph_addr_out_ff),
  .xfer_dir_ff(xfer_dir_ff), .irq_ff(irq_ff));

//--- dmc_periph_model.sv
// peripheral request model: one line pulsed or held high
`timescale 1ns/1ps
module dmc_periph_model (
  input wire sys_clk,
  input wire [6:0] line,
  input wire go,
  input wire hold,
  output reg [127:0] irq_lines
);
  initial irq_lines = 128'h0;
  // a pulse lasts one cycle, so each one is a single trigger
  always @(posedge sys_clk)
  begin
    irq_lines <= 128'h0;
    if (go || hold)
      irq_lines[line] <= 1'b1;
  end
endmodule // dmc_periph_model

//--- dmc_channel_ctrl_tb.sv
// self-checking testbench for the dma channel control block
`timescale 1ns/1ps
module dmc_channel_ctrl_tb;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b1;
  reg [5:0] reg_addr = 6'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [3:0] wcoll = 4'h0;
  reg [6:0] p_line = 7'h00;
  reg p_go = 1'b0;
  reg p_hold = 1'b0;
  wire [127:0] lines;
  wire [31:0] rdata;
  wire [31:0] laddr;
  wire [15:0] paddr;
  wire [3:0] flag;
  wire [3:0] grant;
  wire dir;
  wire irq;
  integer n_fail = 0;
  integer compares = 0;
  integer cyc = 0;
  integer ng = 0;
  integer c;
  integer s;
  reg [31:0] d;
  dmc_channel_ctrl DUT (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
    .periph_irq(lines), .periph_wr_coll(wcoll), .chan_done_flag_ff(flag),
    .xfer_grant_ff(grant), .last_ram_addr_ff(laddr), .periph_addr_out_ff(paddr),
    .xfer_dir_ff(dir), .irq_ff(irq));
  dmc_periph_model u_periph (.sys_clk(sys_clk), .line(p_line), .go(p_go), .hold(p_hold),
    .irq_lines(lines));
  ////////////////////////////////////////////////////////////////////////////
  initial forever #2 sys_clk = ~sys_clk;
  // served elements and hang guard
  always @(posedge sys_clk)
  begin
    ng = ng + (grant != 4'h0);
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  task print_verdict;
  begin
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // bus cycles, each followed by an idle cycle
  task wr(input [5:0] a, input [31:0] v);
  begin
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  end
  endtask
  task rdc(input [5:0] a, input [31:0] e);
  begin
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge sys_clk);
  end
  endtask
  task pulse(input integer n);
  begin
    repeat (n)
    begin
      p_go <= 1'b1;
      @(posedge sys_clk);
      p_go <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
    #1;
  end
  endtask
  function [31:0] wmask(input integer sl);
    wmask = (sl == 5) ? 32'h00003FFF : (sl == 0) ? 32'h0000F833 :
      (sl == 2 || sl == 3) ? 32'hFFFFFFFF : 32'h0000FFFF;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
  begin
    for (c = 0; c < 4; c = c + 1)
      for (s = 0; s < 6; s = s + 1)
        rdc(c * 8 + s, 32'h0);
    rdc(6'h23, 32'h0000000F);
    rdc(6'h07, 32'h0);
    rdc(6'h27, 32'h0);
  end
  endtask
  // widths of every channel register, then channels kept apart
  task t_width;
  begin
    for (c = 0; c < 4; c = c + 1)
      for (s = 0; s < 6; s = s + 1)
      begin
        wr(c * 8 + s, 32'hFFFFFFFF);
        rdc(c * 8 + s, wmask(s));
        wr(c * 8 + s, 32'h0);
      end
    for (c = 0; c < 4; c = c + 1)
      wr(c * 8 + 4, 32'h00000A50 + c);
    for (c = 0; c < 4; c = c + 1)
      rdc(c * 8 + 4, 32'h00000A50 + c);
  end
  endtask
  // one-shot block of four elements on channel 0
  task t_xfer(input sz);
  begin
    p_line <= 7'h05;
    wr(6'h01, 32'h5);
    wr(6'h02, 32'h100);
    wr(6'h04, 32'h1234);
    wr(6'h05, 32'h3);
    wr(6'h26, 32'h1);
    wr(6'h00, sz ? 32'hC001 : 32'h8001);
    ng = 0;
    pulse(5);
    chk(ng, 4);
    chk(laddr, sz ? 32'h103 : 32'h106);
    chk(paddr, 32'h1234);
    chk(dir, 1'b0);
    chk(flag, 4'h1);
    chk(irq, 1'b1);
    rdc(6'h00, sz ? 32'h4001 : 32'h0001);
    rdc(6'h23, 32'h0);
    rdc(6'h24, sz ? 32'h103 : 32'h106);
    wr(6'h26, 32'h0);
    #1 chk(irq, 1'b0);
    wr(6'h25, 32'h1);
    #1 chk(flag, 4'h0);
  end
  endtask
  // completion raised at the midpoint of an eight element block
  task t_half;
  begin
    wr(6'h05, 32'h7);
    wr(6'h00, 32'h9000);
    pulse(3);
    chk(flag, 4'h0);
    pulse(1);
    chk(flag, 4'h1);
    wr(6'h00, 32'h0);
    wr(6'h25, 32'hF);
  end
  endtask
  // channels 0 and 1 alternate on a shared held line, request collision on 1; write collision on 2
  task t_coll;
  begin
    p_line <= 7'h09;
    wr(6'h01, 32'h9);
    wr(6'h09, 32'h9);
    wr(6'h00, 32'h8000);
    wr(6'h08, 32'h8000);
    p_hold <= 1'b1;
    repeat (12) @(posedge sys_clk);
    p_hold <= 1'b0;
    wr(6'h00, 32'h0);
    wr(6'h08, 32'h0);
    reg_addr <= 6'h21;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(rdata[1], 1'b1);
    wr(6'h10, 32'h8000);
    wcoll <= 4'h4;
    repeat (4) @(posedge sys_clk);
    wcoll <= 4'h0;
    repeat (4) @(posedge sys_clk);
    wr(6'h10, 32'h0);
    rdc(6'h20, 32'h4);
    wr(6'h20, 32'hF);
    rdc(6'h20, 32'h0);
  end
  endtask
  initial
  begin
    reset_n = 1'b0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_width;
    t_xfer(1'b1);
    t_xfer(1'b0);
    t_half;
    t_coll;
    print_verdict;
  end
endmodule // dmc_channel_ctrl_tb
